// ===== rss_comp_model.sv
/*
  Comparator behind the rotor sense pin.
  Output follows the requested level after a delay, unrelated to clk_sys.
*/
`timescale 1ns/1ps
module rss_comp_model #(
  parameter real PROP_NS = 2.3
) (
  // Requested level
  input wire logic level_req,
  // Comparator output
  output logic comp_out
);
  initial comp_out = 1'b0;
  always @(level_req) comp_out <= #(PROP_NS) level_req;
endmodule : rss_comp_model

// ===== rss_defines.svh
/*
  Constants for the rotor sense sampling block: register offsets, field
  positions, reset values and event latencies. Assumes a 200 MHz clk_sys.
*/
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// Register port and counter widths
`define RSS_AW 4
`define RSS_DW 16
`define RSS_CW 16

// Register offsets
`define RSS_ADDR_CTRL 4'h0
`define RSS_ADDR_SCF 4'h1
`define RSS_ADDR_STS 4'h2
`define RSS_ADDR_MASK 4'h3
`define RSS_ADDR_ZC 4'h4
`define RSS_ADDR_DM 4'h5
`define RSS_ADDR_TIMER 4'h6
`define RSS_ADDR_STATE 4'h7

// Reset values
`define RSS_CTRL_RST 16'h0000
`define RSS_SCF_RST 16'h0008
`define RSS_MASK_RST 4'h0

// Status and mask bit positions
`define RSS_ST_W 4
`define RSS_ST_ZC 0
`define RSS_ST_DM 1
`define RSS_ST_TACHO 2
`define RSS_ST_READY 3

// State register bit positions
`define RSS_SR_BIT 0
`define RSS_SR_READY 1
`define RSS_SR_COMP 2

// Startup hold-off, rounded up to whole cycles
`define RSS_CLK_MHZ 200
`define RSS_STARTUP_NS 3000
`define RSS_STARTUP_CYC ((`RSS_STARTUP_NS * `RSS_CLK_MHZ + 999) / 1000)

// Latencies in clk_sys edges, first sampling edge counted as one
`define RSS_LAT_SYNC 3
`define RSS_LAT_TACHO 4
`define RSS_LAT_CAP 3
`define RSS_LAT_STATE 1

`endif

// ===== rss_event_delay.sv
/*
  Countdown that fires a one-cycle pulse a loaded number of edges after start.
  Assumes load is at least one; a new start restarts the count.
*/
`timescale 1ns/1ps

module rss_event_delay
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic [`RSS_CW-1:0] load,
  // Event
  output logic fire
);

  logic [`RSS_CW-1:0] cnt_q;
  logic [`RSS_CW-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = load;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Action happens at the edge that ends the last counted cycle
  assign fire = (cnt_q == 16'h0001);

endmodule : rss_event_delay

// ===== rss_pkg.sv
/*
  Types of the rotor sense sampling block: control layout, sampling modes
  and startup states. Assumes rss_defines.svh is on the include path.
*/
`include "rss_defines.svh"

package rss_pkg;

  typedef enum logic [1:0] {
    RSS_MODE_TACHO = 2'h0,
    RSS_MODE_OFF = 2'h1,
    RSS_MODE_ON = 2'h2,
    RSS_MODE_RSVD = 2'h3
  } rss_mode_t;

  typedef struct packed {
    logic [7:0] sampling_delay_field;
    logic [1:0] rsvd;
    logic demag_en;
    logic scf_sel;
    rss_mode_t mode;
    logic ref_en;
    logic comp_en;
  } rss_ctrl_t;

  typedef enum logic [2:0] {
    RSS_OFF = 3'b001,
    RSS_WARM = 3'b010,
    RSS_READY = 3'b100
  } rss_start_t;

endpackage : rss_pkg

// ===== rss_sync.sv
/*
  Two flip-flop synchroniser for the comparator output.
  Assumes an asynchronous single-bit input and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module rss_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic d,
  output logic q
);

  logic s1_q;
  logic s1_d;
  logic s2_q;
  logic s2_d;

  always_comb begin
    s1_d = d;
    s2_d = s1_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign q = s2_q;

endmodule : rss_sync

// ===== rss_top.sv
/*
  Rotor sense input stage: comparator resynchronisation, startup hold-off,
  tacho, back-EMF and demagnetisation captures of a free-running motor timer,
  register port and interrupt. Assumes phase_pwm_output is synchronous to
  clk_sys and rotor_sense_input is asynchronous.
*/
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Turning comparator or reference on waits 3 us before any sampling.
// - Tacho mode captures the timer on the fourth cycle after a toggle.
// - Off-time sampling captures the zero crossing three cycles after PWM rises.
// - Off-time sampling updates the sampled state one cycle after PWM rises.
// - Demag capture follows a toggle by one sampling period plus three cycles.
// - On-time delayed sampling raises zero crossing after delay plus three cycles.
// - With sampling clock chosen, on-time adds one sampling period too.
module rss_top
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [`RSS_AW-1:0] addr,
  input wire logic [`RSS_DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [`RSS_DW-1:0] rd_data,
  // Analog front end and PWM
  input wire logic rotor_sense_input,
  input wire logic phase_pwm_output,
  // Status
  output logic sampled_state_bit,
  output logic irq
);

  function automatic logic [`RSS_CW-1:0] rss_load(input logic [`RSS_CW:0] x);
    logic [`RSS_CW-1:0] r;
    r = x[`RSS_CW-1:0];
    if (x[`RSS_CW]) begin
      r = '1;
    end else if (x[`RSS_CW-1:0] == '0) begin
      r = 16'h0001;
    end
    return r;
  endfunction : rss_load

  // Input conditioning
  logic comp_s;
  logic comp_prev_q;
  logic comp_prev_d;
  logic pwm_prev_q;
  logic pwm_prev_d;
  logic toggle;
  logic rise;

  rss_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(rotor_sense_input),
    .q(comp_s)
  );

  always_comb begin
    comp_prev_d = comp_s;
    pwm_prev_d = phase_pwm_output;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      comp_prev_q <= 1'b0;
      pwm_prev_q <= 1'b0;
    end else begin
      comp_prev_q <= comp_prev_d;
      pwm_prev_q <= pwm_prev_d;
    end
  end

  assign toggle = comp_s ^ comp_prev_q;
  assign rise = phase_pwm_output & ~pwm_prev_q;

  // Configuration registers
  rss_ctrl_t ctrl_q;
  rss_ctrl_t ctrl_d;
  logic [`RSS_CW-1:0] scf_q;
  logic [`RSS_CW-1:0] scf_d;
  logic [`RSS_ST_W-1:0] mask_q;
  logic [`RSS_ST_W-1:0] mask_d;

  always_comb begin
    ctrl_d = ctrl_q;
    scf_d = scf_q;
    mask_d = mask_q;
    if (wr_en) begin
      unique case (addr)
        `RSS_ADDR_CTRL: begin
          ctrl_d = rss_ctrl_t'(wr_data);
          ctrl_d.rsvd = 2'h0;
        end
        `RSS_ADDR_SCF: scf_d = (wr_data == '0) ? 16'h0001 : wr_data;
        `RSS_ADDR_MASK: mask_d = wr_data[`RSS_ST_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= rss_ctrl_t'(`RSS_CTRL_RST);
      scf_q <= `RSS_SCF_RST;
      mask_q <= `RSS_MASK_RST;
    end else begin
      ctrl_q <= ctrl_d;
      scf_q <= scf_d;
      mask_q <= mask_d;
    end
  end

  // Startup hold-off
  rss_start_t st_q;
  rss_start_t st_d;
  logic [`RSS_CW-1:0] hold_q;
  logic [`RSS_CW-1:0] hold_d;
  logic power_on;
  logic ready;
  logic ready_evt;

  assign power_on = ctrl_q.comp_en | ctrl_q.ref_en;

  always_comb begin
    st_d = st_q;
    hold_d = hold_q;
    ready_evt = 1'b0;
    unique case (st_q)
      RSS_OFF: begin
        hold_d = '0;
        if (power_on) begin
          st_d = RSS_WARM;
        end
      end
      RSS_WARM: begin
        hold_d = hold_q + 16'h0001;
        if (!power_on) begin
          st_d = RSS_OFF;
        end else if (hold_q == 16'(`RSS_STARTUP_CYC - 1)) begin
          st_d = RSS_READY;
          ready_evt = 1'b1;
        end
      end
      RSS_READY: begin
        if (!power_on) begin
          st_d = RSS_OFF;
        end
      end
      default: st_d = RSS_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= RSS_OFF;
      hold_q <= '0;
    end else begin
      st_q <= st_d;
      hold_q <= hold_d;
    end
  end

  assign ready = (st_q == RSS_READY);

  // Sampling and capture timing
  logic samp_start;
  logic [`RSS_CW-1:0] samp_load;
  logic samp_fire;
  logic sample_now;
  logic zc_start;
  logic [`RSS_CW-1:0] zc_load;
  logic zc_fire;
  logic dm_start;
  logic [`RSS_CW-1:0] dm_load;
  logic dm_fire;
  logic [`RSS_CW-1:0] scf_extra;
  logic sampled_state_q;
  logic sampled_state_d;

  assign scf_extra = ctrl_q.scf_sel ? scf_q : '0;
  assign samp_start = ready & rise & (ctrl_q.mode == RSS_MODE_ON);
  assign samp_load = rss_load({9'h000, ctrl_q.sampling_delay_field} + {1'b0, scf_extra});
  assign sample_now = ready & (((ctrl_q.mode == RSS_MODE_OFF) & rise)
                      | ((ctrl_q.mode == RSS_MODE_ON) & samp_fire));

  assign zc_start = (sample_now & (comp_s != sampled_state_q))
                    | (ready & (ctrl_q.mode == RSS_MODE_TACHO) & toggle);
  assign zc_load = (ctrl_q.mode == RSS_MODE_TACHO)
                   ? rss_load(17'(`RSS_LAT_TACHO - `RSS_LAT_SYNC))
                   : rss_load(17'(`RSS_LAT_CAP - `RSS_LAT_STATE));
  assign dm_start = ready & ctrl_q.demag_en & toggle;
  assign dm_load = rss_load({1'b0, scf_q} + 17'(`RSS_LAT_CAP - `RSS_LAT_SYNC));

  rss_event_delay u_samp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(samp_start),
    .load(samp_load),
    .fire(samp_fire)
  );

  rss_event_delay u_zc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(zc_start),
    .load(zc_load),
    .fire(zc_fire)
  );

  rss_event_delay u_dm (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(dm_start),
    .load(dm_load),
    .fire(dm_fire)
  );

  // Timer, captures and sampled state
  logic [`RSS_CW-1:0] timer_q;
  logic [`RSS_CW-1:0] timer_d;
  logic [`RSS_CW-1:0] zc_cap_q;
  logic [`RSS_CW-1:0] zc_cap_d;
  logic [`RSS_CW-1:0] dm_cap_q;
  logic [`RSS_CW-1:0] dm_cap_d;
  logic zc_take;
  logic dm_take;

  assign zc_take = ready & zc_fire;
  assign dm_take = ready & dm_fire;

  always_comb begin
    timer_d = timer_q + 16'h0001;
    zc_cap_d = zc_cap_q;
    dm_cap_d = dm_cap_q;
    sampled_state_d = sampled_state_q;
    if (zc_take) begin
      zc_cap_d = timer_q;
    end
    if (dm_take) begin
      dm_cap_d = timer_q;
    end
    if (sample_now) begin
      sampled_state_d = comp_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timer_q <= '0;
      zc_cap_q <= '0;
      dm_cap_q <= '0;
      sampled_state_q <= 1'b0;
    end else begin
      timer_q <= timer_d;
      zc_cap_q <= zc_cap_d;
      dm_cap_q <= dm_cap_d;
      sampled_state_q <= sampled_state_d;
    end
  end

  // Status, interrupt and read port
  logic [`RSS_ST_W-1:0] sts_q;
  logic [`RSS_ST_W-1:0] sts_d;
  logic [`RSS_ST_W-1:0] sts_set;
  logic irq_q;
  logic irq_d;
  logic [`RSS_DW-1:0] rd_q;
  logic [`RSS_DW-1:0] rd_d;

  always_comb begin
    sts_set = '0;
    sts_set[`RSS_ST_ZC] = zc_take & (ctrl_q.mode != RSS_MODE_TACHO);
    sts_set[`RSS_ST_TACHO] = zc_take & (ctrl_q.mode == RSS_MODE_TACHO);
    sts_set[`RSS_ST_DM] = dm_take;
    sts_set[`RSS_ST_READY] = ready_evt;
    sts_d = sts_q;
    if (wr_en && (addr == `RSS_ADDR_STS)) begin
      sts_d = sts_q & ~wr_data[`RSS_ST_W-1:0];
    end
    // Set wins over a clear in the same cycle
    sts_d = sts_d | sts_set;
    irq_d = |(sts_d & mask_d);
    rd_d = '0;
    if (rd_en) begin
      unique case (addr)
        `RSS_ADDR_CTRL: rd_d = ctrl_q;
        `RSS_ADDR_SCF: rd_d = scf_q;
        `RSS_ADDR_STS: rd_d = {12'h000, sts_q};
        `RSS_ADDR_MASK: rd_d = {12'h000, mask_q};
        `RSS_ADDR_ZC: rd_d = zc_cap_q;
        `RSS_ADDR_DM: rd_d = dm_cap_q;
        `RSS_ADDR_TIMER: rd_d = timer_q;
        `RSS_ADDR_STATE: begin
          rd_d[`RSS_SR_BIT] = sampled_state_q;
          rd_d[`RSS_SR_READY] = ready;
          rd_d[`RSS_SR_COMP] = comp_s;
        end
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sts_q <= '0;
      irq_q <= 1'b0;
      rd_q <= '0;
    end else begin
      sts_q <= sts_d;
      irq_q <= irq_d;
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
  assign irq = irq_q;
  assign sampled_state_bit = sampled_state_q;

endmodule : rss_top

// ===== rss_top_asserts.sv
/*
  Port checker for rss_top.
  Bound to every rss_top instance below.
*/
`timescale 1ns/1ps
`include "rss_defines.svh"
module rss_top_asserts
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [`RSS_AW-1:0] addr,
  input wire logic [`RSS_DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [`RSS_DW-1:0] rd_data,
  // Front end and status
  input wire logic rotor_sense_input,
  input wire logic phase_pwm_output,
  input wire logic sampled_state_bit,
  input wire logic irq
);
  rss_ctrl_t ctrl_q;
  rss_ctrl_t ctrl_d;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic tacho;
  logic offm;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Shadow of control and mask
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    if (wr_en && addr == `RSS_ADDR_CTRL) ctrl_d = wr_data;
    if (wr_en && addr == `RSS_ADDR_MASK) mask_d = wr_data[3:0];
  end
  always_ff @(posedge clk_sys) begin
    ctrl_q <= rst_n ? ctrl_d : '0;
    mask_q <= rst_n ? mask_d : 4'h0;
  end
  assign tacho = ctrl_q.mode == RSS_MODE_TACHO && !ctrl_q.demag_en;
  assign offm = ctrl_q.mode == RSS_MODE_OFF && !ctrl_q.demag_en;
  chk_rd_idle: assert property (!$past(rd_en) |-> rd_data == '0)
    else $error("read data outside read cycle");
  chk_rd_unmap: assert property (rd_en && addr[3] |=> rd_data == '0)
    else $error("unmapped read not zero");
  chk_timer_step: assert property ((rd_en && addr == `RSS_ADDR_TIMER) ##1 (rd_en && addr == `RSS_ADDR_TIMER)
    |=> rd_data == $past(rd_data) + 16'h0001) else $error("timer not stepping");
  chk_mask_quiet: assert property (wr_en && addr == `RSS_ADDR_MASK && wr_data[3:0] == 4'h0 |=> !irq)
    else $error("irq with mask clear");
  chk_state_read: assert property (rd_en && addr == `RSS_ADDR_STATE |=> rd_data[0] == $past(sampled_state_bit))
    else $error("state read mismatch");
  chk_reset_quiet: assert property ($rose(rst_n) |-> !irq && !sampled_state_bit && rd_data == '0)
    else $error("outputs not cleared by reset");
  chk_state_src: assert property (
    offm && $changed(sampled_state_bit) |-> $past(phase_pwm_output) && !$past(phase_pwm_output, 2)
    && sampled_state_bit == $past(rotor_sense_input, 3)) else $error("sampled state timing");
  chk_tacho_irq: assert property (
    tacho && mask_q == 4'h4 && $rose(irq) && !$past(wr_en)
    |-> $past(rotor_sense_input, 4) != $past(rotor_sense_input, 5)) else $error("tacho latency");
  chk_zc_irq: assert property (
    offm && mask_q == 4'h1 && $rose(irq) && !$past(wr_en)
    |-> $past(phase_pwm_output, 3) && !$past(phase_pwm_output, 4)) else $error("zero cross latency");
  cov_tacho: cover property (tacho && $rose(irq));
  cov_zc: cover property (offm && $rose(irq));
  cov_state: cover property (offm && $changed(sampled_state_bit));
endmodule : rss_top_asserts

bind rss_top rss_top_asserts rss_top_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rotor_sense_input(rotor_sense_input),
  .phase_pwm_output(phase_pwm_output), .sampled_state_bit(sampled_state_bit), .irq(irq));

// ===== rss_top_tb.sv
/*
  Self-checking bench for rss_top: reset values, startup, event latencies.
  Needs the comparator model and the checker in the same compile.
*/
`timescale 1ns/1ps
`include "rss_defines.svh"
module rss_top_tb
  import rss_pkg::*;
;
  localparam int STARTUP = 3000 * 200 / 1000;
  localparam int DLY = 5;
  localparam int DIV = 4;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rd_data;
  logic level_req = 1'b0;
  logic rotor_sense_input;
  logic phase_pwm_output = 1'b0;
  logic sampled_state_bit;
  logic irq;
  logic [15:0] t0;
  logic [15:0] tmr = 16'h0000;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [19:0] rows [8] = '{{`RSS_ADDR_CTRL, 16'h0000}, {`RSS_ADDR_SCF, 16'h0001}, {`RSS_ADDR_STS, 16'h0000},
    {`RSS_ADDR_MASK, 16'h0000}, {`RSS_ADDR_ZC, 16'h0000}, {`RSS_ADDR_DM, 16'h0000},
    {`RSS_ADDR_STATE, 16'h0000}, {4'hc, 16'h0000}};
  always #2.5 clk_sys = ~clk_sys;
  rss_top rss_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .rotor_sense_input(rotor_sense_input),
    .phase_pwm_output(phase_pwm_output), .sampled_state_bit(sampled_state_bit), .irq(irq));
  rss_comp_model rss_comp_model_inst (.level_req(level_req), .comp_out(rotor_sense_input));
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rd_data & m, exp);
  endtask : rd
  // Event latency counted from the edge that launches the cause
  task automatic ev(input logic [15:0] c, input logic [3:0] m, input logic early, input int li, input int ls);
    int ni;
    int ns;
    logic s0;
    logic [15:0] tc;
    ni = 0;
    ns = 0;
    wr(`RSS_ADDR_CTRL, c);
    wr(`RSS_ADDR_STS, 16'h000f);
    wr(`RSS_ADDR_MASK, {12'h000, m});
    @(posedge clk_sys);
    phase_pwm_output <= 1'b0;
    if (early) level_req <= ~sampled_state_bit;
    repeat (4) @(posedge clk_sys);
    s0 = sampled_state_bit;
    tc = tmr + 16'(li);
    if (!early) level_req <= ~level_req;
    phase_pwm_output <= 1'b1;
    for (int n = 1; n <= 40; n++) begin
      @(posedge clk_sys);
      #1;
      if (ns == 0 && sampled_state_bit !== s0) ns = n;
      if (ni == 0 && irq === 1'b1) ni = n;
    end
    chk(16'(ni), 16'(li));
    if (ls != 0) chk(16'(ns), 16'(ls));
    rd((m == 4'h2) ? `RSS_ADDR_DM : `RSS_ADDR_ZC, tc, 16'hffff);
    rd(`RSS_ADDR_STS, {12'h000, m}, {12'h000, m});
    wr(`RSS_ADDR_MASK, 16'h0000);
    #1;
    chk({15'h0000, irq}, 16'h0000);
  endtask : ev
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    tmr <= rst_n ? tmr + 16'h0001 : 16'h0000;
    if (cycles == 3000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(`RSS_ADDR_ZC, 16'hffff);
    wr(`RSS_ADDR_SCF, 16'h0000);
    foreach (rows[i]) rd(rows[i][19:16], rows[i][15:0], 16'hffff);
    $display("end reset values");
    wr(`RSS_ADDR_CTRL, 16'h0001);
    repeat (STARTUP - 20) @(posedge clk_sys);
    rd(`RSS_ADDR_STATE, 16'h0000, 16'h0002);
    repeat (30) @(posedge clk_sys);
    rd(`RSS_ADDR_STATE, 16'h0002, 16'h0002);
    rd(`RSS_ADDR_STS, 16'h0008, 16'h0008);
    $display("end startup");
    ev(16'h0001, 4'h4, 1'b0, 4, 0);
    ev(16'h0005, 4'h1, 1'b1, 3, 1);
    ev({8'(DLY), 8'h09}, 4'h1, 1'b1, DLY + 3, DLY + 1);
    wr(`RSS_ADDR_SCF, 16'(DIV));
    ev({8'(DLY), 8'h19}, 4'h1, 1'b1, DLY + DIV + 3, DLY + DIV + 1);
    ev(16'h002d, 4'h2, 1'b0, DIV + 3, 0);
    $display("end events");
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= `RSS_ADDR_TIMER;
    repeat (2) @(posedge clk_sys);
    #1;
    t0 = rd_data;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, t0 + 16'h0001);
    $display("end timer");
    wr(`RSS_ADDR_MASK, 16'h0002);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk({15'h0000, irq}, 16'h0000);
    rd(`RSS_ADDR_CTRL, 16'h0000, 16'hffff);
    rd(`RSS_ADDR_MASK, 16'h0000, 16'hffff);
    $display("end second reset");
    test_done();
  end
endmodule : rss_top_tb
